//--- include/dtpi_pkg.sv
package dtpi_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NumCh  = 12;
  localparam int NumLvl = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OffSoftTrig  = 12'h010;
  localparam logic [11:0] OffLevelPri  = 12'h014;
  localparam logic [11:0] OffIntSum    = 12'h020;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RstSoftTrig  = 32'h0000_0000;
  localparam logic [31:0] RstLevelPri  = 32'h0000_0000;
  localparam logic [15:0] RstIntSum    = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LvlStride   = 8;   // Each level owns one byte
  localparam int LvlRotBit   = 7;   // Rotation select within the byte
  localparam int SumWaitBit  = 15;
  localparam int SumBusyBit  = 14;
  localparam int SumFaultBit = 13;
  localparam int SumHaltBit  = 10;
  localparam int SumDoneBit  = 9;
  localparam int SumErrBit   = 8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DTPI_IDLE   = 2'b00,
    DTPI_ACCESS = 2'b01
  } dtpi_bus_state_t;

  typedef struct packed {
    logic        halt;
    logic        done;
    logic        fault;
  } dtpi_int_flags_t;

  typedef struct packed {
    logic [NumLvl-1:0] rotate;
    logic [NumLvl-1:0][3:0] lastGranted;
  } dtpi_level_cfg_t;

endpackage

//--- rtl/dtpi_level_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module dtpi_level_arbiter (
  input  wire logic [11:0] req,        // Requests of this level's channels
  input  wire logic        rotate,     // Round-robin select
  input  wire logic [3:0]  lastGrant,  // Last acknowledged channel
  output var  logic        grantValid, // Some channel granted
  output var  logic [3:0]  grantCh     // Granted channel number
);

  // ----------------------------------------------------------------
  // Pick winner
  // ----------------------------------------------------------------
  // Round robin starts the search just after the stored channel
  always_comb begin
    logic [4:0] idx;
    logic [3:0] start;
    idx        = 5'h00;
    grantValid = 1'b0;
    grantCh    = 4'h0;
    start      = 4'h0;
    if (rotate) begin
      start = (lastGrant >= 4'd11) ? 4'h0 : 4'(lastGrant + 4'h1);
    end
    for (int k = 0; k < 12; k++) begin
      idx = 5'(start) + 5'(k);
      if (idx >= 5'd12) begin
        idx = 5'(idx - 5'd12);
      end
      if (!grantValid && req[idx[3:0]]) begin
        grantValid = 1'b1;
        grantCh    = idx[3:0];
      end
    end
  end

endmodule // dtpi_level_arbiter
`default_nettype wire

//--- rtl/dtpi_flag_store.sv
`timescale 1ns/1ps
`default_nettype none
module dtpi_flag_store (
  input  wire logic                   ref_clk,  // System clock
  input  wire logic                   resetn,   // Sync reset, active low
  input  wire dtpi_pkg::dtpi_int_flags_t [11:0] setFlags, // Per-channel set pulses
  input  wire logic                   clrEn,    // Clear strobe
  input  wire logic [3:0]             clrCh,    // Channel to clear
  input  wire dtpi_pkg::dtpi_int_flags_t clrMask, // Flags to clear
  output var  dtpi_pkg::dtpi_int_flags_t [11:0] flags_ff // Stored flags
);

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  // Set wins over clear so an event in the clear cycle survives
  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < 12; c++) begin
      if (!resetn) begin
        flags_ff[c] <= '0;
      end else if (clrEn && clrCh == 4'(c)) begin
        flags_ff[c] <= (flags_ff[c] & ~clrMask) | setFlags[c];
      end else begin
        flags_ff[c] <= flags_ff[c] | setFlags[c];
      end
    end
  end

endmodule // dtpi_flag_store
`default_nettype wire

//--- rtl/dtpi_controller.sv
`timescale 1ns/1ps
`default_nettype none
module dtpi_controller (
  input  wire logic        ref_clk,        // 20 MHz system clock
  input  wire logic        resetn,         // Sync reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [11:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error on unmapped
  input  wire logic [11:0] chanWaiting,    // Channel waiting status
  input  wire logic [11:0] chanBusy,       // Channel busy status
  input  wire logic [11:0] descFault,      // Descriptor fault per channel
  input  wire logic [11:0] hwRequest,      // Peripheral trigger requests
  input  wire logic [23:0] chanLevel,      // Two-bit level per channel
  input  wire logic        grantTake,      // Arbiter may grant now
  input  wire logic [11:0] haltEvent,      // Halt interrupt events
  input  wire logic [11:0] doneEvent,      // Done interrupt events
  input  wire logic [11:0] faultEvent,     // Fault interrupt events
  output logic      [11:0] softTrigReq,    // Software trigger requests
  output logic             grantValid,     // Grant issued this cycle
  output logic      [3:0]  grantCh,        // Granted channel
  output logic      [1:0]  grantLvl        // Level of granted channel
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lowest bit of one level's byte in the priority register
  function automatic int lvlBase(input int lvl);
    return lvl * dtpi_pkg::LvlStride;
  endfunction

  // Selector values above the last channel name no channel, so their
  // status reads zero instead of indexing past the vectors
  function automatic logic chValid(input logic [3:0] ch);
    return ch < 4'(dtpi_pkg::NumCh);
  endfunction

  // Highest level with a winner; level three outranks the others
  function automatic logic [1:0] topLevel(input logic [3:0] valid);
    logic [1:0] lvl;
    lvl = 2'd0;
    for (int l = 0; l < 4; l++) begin
      if (valid[l]) begin
        lvl = 2'(l);
      end
    end
    return lvl;
  endfunction

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  dtpi_pkg::dtpi_bus_state_t busState_ff;
  logic        setupHit;
  logic        wrStrobe;
  logic        rdStrobe;
  logic        hitTrig;
  logic        hitLvl;
  logic        hitSum;
  logic        unmapped;

  assign setupHit = psel && !penable;
  assign hitTrig  = paddr == dtpi_pkg::OffSoftTrig;
  assign hitLvl   = paddr == dtpi_pkg::OffLevelPri;
  assign hitSum   = paddr == dtpi_pkg::OffIntSum;
  assign unmapped = !(hitTrig || hitLvl || hitSum);
  // Every access answers in its first access cycle
  assign wrStrobe = psel && penable && pwrite && busState_ff == dtpi_pkg::DTPI_ACCESS;
  assign rdStrobe = psel && penable && !pwrite && busState_ff == dtpi_pkg::DTPI_ACCESS;

  // Setup moves to access; ready rises for exactly one cycle
  // The state qualifies the write and read strobes, so a master that holds
  // penable after its answer cannot commit the same write twice
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      busState_ff <= dtpi_pkg::DTPI_IDLE;
    end else begin
      case (busState_ff)
        dtpi_pkg::DTPI_IDLE:   busState_ff <= setupHit ? dtpi_pkg::DTPI_ACCESS
                                                       : dtpi_pkg::DTPI_IDLE;
        dtpi_pkg::DTPI_ACCESS: busState_ff <= dtpi_pkg::DTPI_IDLE;
        default:               busState_ff <= dtpi_pkg::DTPI_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software trigger register
  // ----------------------------------------------------------------
  logic [11:0] softPend_ff;    // Trigger waiting to be taken
  logic [11:0] softBusyRd_ff;  // Readback: one written while waiting
  logic [11:0] waitPrev_ff;
  logic [11:0] waitRise;
  logic [11:0] nxt_softPend;
  logic [11:0] nxt_softBusyRd;
  logic [11:0] trigWr;
  logic        trigWrEn;

  assign trigWrEn = wrStrobe && hitTrig;
  assign waitRise = chanWaiting & ~waitPrev_ff;
  assign trigWr   = trigWrEn ? pwdata[11:0] : 12'h000;

  // The hardware clear is applied last: a write landing in the cycle
  // in which the waiting flag rises is absorbed by that transfer
  always_comb begin
    nxt_softPend   = softPend_ff;
    nxt_softBusyRd = softBusyRd_ff;
    if (trigWrEn) begin
      nxt_softPend   = trigWr;
      nxt_softBusyRd = trigWr & chanWaiting;
    end
    nxt_softPend   = nxt_softPend & ~waitRise;
    nxt_softBusyRd = nxt_softBusyRd & ~waitRise;
  end

  // Only the pending part drives the request; readback is status only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      softPend_ff   <= dtpi_pkg::RstSoftTrig[11:0];
      softBusyRd_ff <= dtpi_pkg::RstSoftTrig[11:0];
      waitPrev_ff   <= 12'h000;
      softTrigReq   <= 12'h000;
    end else begin
      softPend_ff   <= nxt_softPend;
      softBusyRd_ff <= nxt_softBusyRd;
      waitPrev_ff   <= chanWaiting;
      softTrigReq   <= nxt_softPend & ~chanWaiting;
    end
  end

  // ----------------------------------------------------------------
  // Priority levels and arbitration
  // ----------------------------------------------------------------
  dtpi_pkg::dtpi_level_cfg_t lvlCfg_ff;
  dtpi_pkg::dtpi_level_cfg_t nxt_lvlCfg;
  logic [3:0][11:0] lvlReq;
  logic [3:0]       lvlValid;
  logic [3:0][3:0]  lvlCh;
  logic [11:0]      allReq;
  logic [1:0]       winLvl;
  logic             winAny;
  logic             grantNow;
  logic             lvlWrEn;

  assign allReq   = hwRequest | softTrigReq;
  assign lvlWrEn  = wrStrobe && hitLvl;

  // Requests sorted into the four levels
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      for (int c = 0; c < 12; c++) begin
        lvlReq[l][c] = allReq[c] && chanLevel[2*c +: 2] == 2'(l);
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : gLvl
    dtpi_level_arbiter dtpi_level_arbiter_inst (
      .req        (lvlReq[g]),
      .rotate     (lvlCfg_ff.rotate[g]),
      .lastGrant  (lvlCfg_ff.lastGranted[g]),
      .grantValid (lvlValid[g]),
      .grantCh    (lvlCh[g])
    );
  end

  // Highest level wins across levels
  assign winAny   = |lvlValid;
  assign winLvl   = topLevel(lvlValid);
  // A grant needs both permission and a requester somewhere
  assign grantNow = grantTake && winAny;

  always_comb begin
    nxt_lvlCfg = lvlCfg_ff;
    // Turning rotation off loads the field from the written bits like any write;
    // the arbiter ignores it while rotation is off, so the static order needs no zero write
    if (lvlWrEn) begin
      for (int l = 0; l < 4; l++) begin
        nxt_lvlCfg.rotate[l]      = pwdata[lvlBase(l) + dtpi_pkg::LvlRotBit];
        nxt_lvlCfg.lastGranted[l] = pwdata[lvlBase(l) +: 4];
      end
    end
    // Hardware update only for rotating levels; static levels keep the field
    if (grantNow && lvlCfg_ff.rotate[winLvl]) begin
      nxt_lvlCfg.lastGranted[winLvl] = lvlCh[winLvl];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lvlCfg_ff  <= '0;
      grantValid <= 1'b0;
      grantCh    <= 4'h0;
      grantLvl   <= 2'd0;
    end else begin
      lvlCfg_ff  <= nxt_lvlCfg;
      grantValid <= grantNow;
      grantCh    <= lvlCh[winLvl];
      grantLvl   <= winLvl;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags and summary
  // ----------------------------------------------------------------
  dtpi_pkg::dtpi_int_flags_t [11:0] setFlags;
  dtpi_pkg::dtpi_int_flags_t [11:0] flags;
  dtpi_pkg::dtpi_int_flags_t        clrMask;
  dtpi_pkg::dtpi_int_flags_t        selFlags;
  logic [3:0]  selCh_ff;
  logic [3:0]  lowestCh;
  logic        anyInt;
  logic        sumWr;
  logic        lowerArrived;
  logic [11:0] chanInt;

  // Any stored flag of a channel makes it a summary candidate
  always_comb begin
    for (int c = 0; c < 12; c++) begin
      setFlags[c] = '{halt: haltEvent[c], done: doneEvent[c], fault: faultEvent[c]};
      chanInt[c]  = |flags[c];
    end
  end

  assign sumWr   = wrStrobe && hitSum;
  assign clrMask = '{halt:  pwdata[dtpi_pkg::SumHaltBit],
                     done:  pwdata[dtpi_pkg::SumDoneBit],
                     fault: pwdata[dtpi_pkg::SumErrBit]};

  // A clear aimed at a selector above eleven matches no channel
  dtpi_flag_store dtpi_flag_store_inst (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .setFlags (setFlags),
    .clrEn    (sumWr),
    .clrCh    (pwdata[3:0]),
    .clrMask  (clrMask),
    .flags_ff (flags)
  );

  // Lowest-numbered channel with any stored flag
  always_comb begin
    lowestCh = 4'h0;
    anyInt   = 1'b0;
    for (int c = 11; c >= 0; c--) begin
      if (chanInt[c]) begin
        lowestCh = 4'(c);
        anyInt   = 1'b1;
      end
    end
  end

  // An invalid selector counts as empty, so the next flag claims it
  assign lowerArrived = anyInt && (lowestCh < selCh_ff || !chValid(selCh_ff) ||
                                   !chanInt[selCh_ff]);

  // Selector follows software writes, else refreshes on a lower arrival
  // or once the selected channel has no flag left
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      selCh_ff <= dtpi_pkg::RstIntSum[3:0];
    end else if (sumWr) begin
      selCh_ff <= pwdata[3:0];
    end else if (lowerArrived || !anyInt) begin
      selCh_ff <= lowestCh;
    end
  end

  assign selFlags = chValid(selCh_ff) ? flags[selCh_ff] : '0;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rdLvl;
  logic [15:0] rdSum;
  logic [31:0] rdData;

  // Reserved bits start at zero and only named fields are filled in,
  // so no write pattern can make a reserved bit read back as one
  always_comb begin
    rdLvl = 32'h0000_0000;
    for (int l = 0; l < 4; l++) begin
      rdLvl[lvlBase(l) +: 4] = lvlCfg_ff.lastGranted[l];
      rdLvl[lvlBase(l) + dtpi_pkg::LvlRotBit] = lvlCfg_ff.rotate[l];
    end
    rdSum = 16'h0000;
    rdSum[3:0] = selCh_ff;
    if (chValid(selCh_ff)) begin
      rdSum[dtpi_pkg::SumWaitBit]  = chanWaiting[selCh_ff];
      rdSum[dtpi_pkg::SumBusyBit]  = chanBusy[selCh_ff];
      rdSum[dtpi_pkg::SumFaultBit] = descFault[selCh_ff];
    end
    rdSum[dtpi_pkg::SumHaltBit] = selFlags.halt;
    rdSum[dtpi_pkg::SumDoneBit] = selFlags.done;
    rdSum[dtpi_pkg::SumErrBit]  = selFlags.fault;
  end

  assign rdData = hitTrig ? {20'h00000, softBusyRd_ff} :
                  hitLvl  ? rdLvl :
                  hitSum  ? {16'h0000, rdSum} : 32'h0000_0000;

  // Bus outputs registered; ready is high in the first access cycle
  // Read data is zero outside an answer, keeping stale values off the bus
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (setupHit && !pwrite) ? rdData : 32'h0000_0000;
      pready  <= setupHit;
      pslverr <= setupHit && unmapped;
    end
  end

endmodule // dtpi_controller
`default_nettype wire

//--- verif/dtpi_controller_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dtpi_controller_chk (
  input wire logic        ref_clk,     // System clock
  input wire logic        resetn,      // Sync reset, active low
  input wire logic        psel,        // APB select
  input wire logic        penable,     // APB enable
  input wire logic [31:0] prdata,      // APB read data
  input wire logic        pready,      // APB ready
  input wire logic        pslverr,     // APB error
  input wire logic [11:0] chanWaiting, // Waiting status
  input wire logic [11:0] hwRequest,   // Peripheral requests
  input wire logic [23:0] chanLevel,   // Level per channel
  input wire logic        grantTake,   // Grant allowed
  input wire logic [11:0] softTrigReq, // Software requests
  input wire logic        grantValid,  // Grant pulse
  input wire logic [3:0]  grantCh,     // Granted channel
  input wire logic [1:0]  grantLvl     // Granted level
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  sequence seq_setup;
    psel && !penable;
  endsequence
  sequence seq_access;
    psel && penable;
  endsequence
  // Zero wait states, so a master never stalls on this block
  a_ready_first: assert property (seq_setup ##1 seq_access |-> pready)
    else $error("pready missing in first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside answer");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer carries data");
  // ----------------------------------------------------------------
  // Requests and grants
  // ----------------------------------------------------------------
  a_trig_drop: assert property ((softTrigReq & $past(chanWaiting)) == 12'h000)
    else $error("software request kept after waiting rose");
  a_grant_cause: assert property (grantValid |-> $past(grantTake))
    else $error("grant without permission");
  a_grant_req: assert property (grantValid |->
    ((($past(hwRequest) | $past(softTrigReq)) >> grantCh) & 12'h001) != 12'h000)
    else $error("grant to a channel without request");
  a_grant_lvl: assert property (grantValid |->
    grantLvl == 2'($past(chanLevel) >> {grantCh, 1'b0}))
    else $error("grant level does not match channel");
endmodule // dtpi_controller_chk

bind dtpi_controller dtpi_controller_chk dtpi_controller_chk_inst (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .chanWaiting(chanWaiting), .hwRequest(hwRequest),
  .chanLevel(chanLevel), .grantTake(grantTake), .softTrigReq(softTrigReq),
  .grantValid(grantValid), .grantCh(grantCh), .grantLvl(grantLvl));
`default_nettype wire

//--- verif/dtpi_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dtpi_bench;
  logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        grantTake, grantValid, errSeen;
  logic [11:0] paddr, chanWaiting, chanBusy, descFault, hwRequest;
  logic [11:0] haltEvent, doneEvent, faultEvent, softTrigReq, req;
  logic [31:0] pwdata, prdata, rdBack, rng;
  logic [23:0] chanLevel;
  logic [3:0]  grantCh;
  logic [1:0]  grantLvl;
  logic [15:0] wrTab [6] = '{16'h0, 16'h0103, 16'h0209, 16'h0207, 16'h0009, 16'h0409};
  logic [15:0] rdTab [6] = '{16'he103, 16'h0207, 16'h0207, 16'h0409, 16'h0409, 16'h0};
  int          n_errors, checked, l, i;

  dtpi_controller dtpi_controller_inst (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chanWaiting(chanWaiting), .chanBusy(chanBusy),
    .descFault(descFault), .hwRequest(hwRequest), .chanLevel(chanLevel),
    .grantTake(grantTake), .haltEvent(haltEvent), .doneEvent(doneEvent),
    .faultEvent(faultEvent), .softTrigReq(softTrigReq), .grantValid(grantValid),
    .grantCh(grantCh), .grantLvl(grantLvl));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Static winner: highest level, then lowest channel number
  function automatic logic [6:0] expGrant(input logic [11:0] r, input logic [23:0] lv);
    int bl, bc;
    bl = -1;
    bc = 0;
    for (int c = 0; c < 12; c++) begin
      if (r[c] && int'(lv[2*c +: 2]) > bl) begin
        bl = lv[2*c +: 2];
        bc = c;
      end
    end
    return {1'b1, 2'(bl), 4'(bc)};
  endfunction

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the wait for pready is bounded
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    rdBack = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      n_errors++;
      test_done();
    end
  endtask

  // Requests are offered for exactly one permitted edge
  task automatic grantTry(input logic [11:0] r);
    @(posedge ref_clk);
    hwRequest <= r;
    grantTake <= 1'b1;
    @(posedge ref_clk);
    hwRequest <= 12'h000;
    grantTake <= 1'b0;
    #1;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {resetn, psel, penable, pwrite, grantTake} = '0;
    {paddr, chanWaiting, chanBusy, descFault, hwRequest} = '0;
    {haltEvent, doneEvent, faultEvent, pwdata, chanLevel} = '0;
    n_errors = 0;
    checked = 0;
    rng = 32'h48fcc73e;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    apb(0, dtpi_pkg::OffSoftTrig, 32'h0); check("trig reset", rdBack, 32'h0);
    apb(0, dtpi_pkg::OffLevelPri, 32'h0); check("level reset", rdBack, 32'h0);
    apb(0, dtpi_pkg::OffIntSum, 32'h0); check("sum reset", rdBack, 32'h0);
    apb(0, 12'h0fc, 32'h0); check("unmapped rd", rdBack, 32'h0);
    check("unmapped err", {31'h0, errSeen}, 32'h1);
    $display("test resets done");
    for (i = 0; i < 6; i++) begin
      rng = xs(rng);
      apb(1, dtpi_pkg::OffLevelPri, rng & 32'h8f8f8f8f);
      apb(0, dtpi_pkg::OffLevelPri, 32'h0);
      check("level rw", rdBack, rng & 32'h8f8f8f8f);
    end
    apb(1, dtpi_pkg::OffLevelPri, 32'h0);
    $display("test level register done");
    for (l = 0; l < 4; l++) begin
      chanLevel <= {12{l[1:0]}};
      apb(1, dtpi_pkg::OffLevelPri, 32'h85 << (8 * l));
      grantTry(12'h224); check("rr grant", {grantValid, grantLvl, grantCh}, {1'b1, l[1:0], 4'h9});
      apb(0, dtpi_pkg::OffLevelPri, 32'h0); check("rr last", rdBack, 32'h89 << (8 * l));
      grantTry(12'h224); check("rr wrap", {grantValid, grantLvl, grantCh}, {1'b1, l[1:0], 4'h2});
      apb(1, dtpi_pkg::OffLevelPri, 32'h02 << (8 * l));
      grantTry(12'h220); check("st grant", {grantValid, grantLvl, grantCh}, {1'b1, l[1:0], 4'h5});
      apb(0, dtpi_pkg::OffLevelPri, 32'h0); check("st keep", rdBack, 32'h02 << (8 * l));
      apb(1, dtpi_pkg::OffLevelPri, 32'h0);
    end
    for (i = 0; i < 10; i++) begin
      rng = xs(rng);
      req = (rng[11:0] == 12'h000) ? 12'h001 : rng[11:0];
      @(posedge ref_clk);
      chanLevel <= rng[31:8];
      grantTry(req); check("level win", {grantValid, grantLvl, grantCh}, expGrant(req, rng[31:8]));
    end
    $display("test arbitration done");
    for (l = 0; l < 12; l += 11) begin
      apb(1, dtpi_pkg::OffSoftTrig, 32'h1 << l);
      #1; check("trig req", softTrigReq, 12'h001 << l);
      apb(0, dtpi_pkg::OffSoftTrig, 32'h0); check("trig rd0", rdBack, 32'h0);
      apb(1, dtpi_pkg::OffSoftTrig, 32'h0);
      #1; check("trig cancel", softTrigReq, 12'h000);
      apb(1, dtpi_pkg::OffSoftTrig, 32'h1 << l);
      chanWaiting <= 12'h001 << l;
      repeat (2) @(posedge ref_clk);
      #1; check("trig drop", softTrigReq, 12'h000);
      apb(1, dtpi_pkg::OffSoftTrig, 32'h1 << l);
      apb(0, dtpi_pkg::OffSoftTrig, 32'h0); check("trig rd1", rdBack, 32'h1 << l);
      apb(1, dtpi_pkg::OffSoftTrig, 32'h0000_0000);
      apb(0, dtpi_pkg::OffSoftTrig, 32'h0); check("trig clr", rdBack, 32'h0);
      chanWaiting <= 12'h000;
    end
    $display("test software trigger done");
    @(posedge ref_clk);
    {doneEvent, faultEvent, haltEvent} <= {12'h080, 12'h008, 12'h200};
    {chanWaiting, chanBusy, descFault} <= {3{12'h008}};
    @(posedge ref_clk);
    {doneEvent, faultEvent, haltEvent} <= '0;
    for (i = 0; i < 6; i++) begin
      if (i > 0) apb(1, dtpi_pkg::OffIntSum, {16'h0, wrTab[i]});
      apb(0, dtpi_pkg::OffIntSum, 32'h0);
      check("summary", rdBack, {16'h0, rdTab[i]});
    end
    $display("test interrupt summary done");
    test_done();
  end
endmodule // dtpi_bench
`default_nettype wire
